// >>> hw/nv_pkg.sv
/*
 * Constants, layouts and state types shared by the nonvolatile byte
 * array controller, its array and its self-timer.
 * Assumes a single 200 MHz core clock.
 */
package nv_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int DEPTH = 1024;
    localparam int CNT_W = 20;
    localparam int ADDR_HIGH_W = 2;
    typedef logic [CNT_W-1:0] cnt_t;
    localparam cnt_t CNT_ONE = 20'h00001;

    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

    // Register select codes of the special function register port
    localparam logic [2:0] SEL_ADDR_HIGH = 3'h0;
    localparam logic [2:0] SEL_ADDR_LOW = 3'h1;
    localparam logic [2:0] SEL_DATA = 3'h2;
    localparam logic [2:0] SEL_UNLOCK = 3'h3;
    localparam logic [2:0] SEL_CONTROL = 3'h4;
    localparam logic [2:0] SEL_PFLAG6 = 3'h5;

    // Bit positions of nv_access_control and peripheral_flag_reg_six
    localparam int CTL_PGD = 7;
    localparam int CTL_CFG = 6;
    localparam int CTL_FREE = 4;
    localparam int CTL_ERR = 3;
    localparam int CTL_PERMIT = 2;
    localparam int CTL_WR = 1;
    localparam int CTL_RD = 0;
    localparam int DONE_BIT = 4;

    // Self-timed write phases
    localparam int CLK_PERIOD_NS = 5;
    localparam int ERASE_TIME_NS = 2000000;
    localparam int PROGRAM_TIME_NS = 2000000;
    localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RD_ISSUE = 3'h1,
        ST_RD_LOAD = 3'h2,
        ST_ERASE = 3'h3,
        ST_PROGRAM = 3'h4
    } ctrl_state_t;

    typedef enum logic [1:0] {
        LK_NONE = 2'h0,
        LK_FIRST = 2'h1,
        LK_ARMED = 2'h2
    } lock_state_t;
endpackage

// >>> hw/nv_links.sv
/*
 * Carriers between the controller and its array and timer.
 * Assumes all three modules share one clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface nv_array_if;
    logic rd_en;
    logic wr_en;
    logic [nv_pkg::ADDR_W-1:0] addr;
    logic [nv_pkg::DATA_W-1:0] wdata;
    logic [nv_pkg::DATA_W-1:0] rdata;
    modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
    modport array (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

interface nv_timer_if;
    logic start;
    nv_pkg::cnt_t load;
    logic done;
    modport ctrl (output start, output load, input done);
    modport timer (input start, input load, output done);
endinterface
`default_nettype wire

// >>> hw/nv_byte_array.sv
/*
 * The 1024 x 8 nonvolatile cell array with a registered read port.
 * Assumes the controller never reads and writes in the same cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module nv_byte_array (
    input wire logic clk,
    input wire logic reset_n,
    nv_array_if.array mem
);
    typedef struct packed {
        logic [nv_pkg::DATA_W-1:0] rdata;
    } array_state_t;

    logic [nv_pkg::DATA_W-1:0] cells [0:nv_pkg::DEPTH-1];
    array_state_t st_r;
    array_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (mem.rd_en) begin
            st_nxt.rdata = cells[mem.addr];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Cells hold their contents through reset
    always_ff @(posedge clk) begin
        if (mem.wr_en) begin
            cells[mem.addr] <= mem.wdata;
        end
    end

    assign mem.rdata = st_r.rdata;
endmodule
`default_nettype wire

// >>> hw/nv_write_timer.sv
/*
 * Self-timer for the erase and program phases of a byte write.
 * Assumes start is a one-cycle pulse; done pulses after load cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module nv_write_timer (
    input wire logic clk,
    input wire logic reset_n,
    nv_timer_if.timer tmr
);
    typedef struct packed {
        logic run;
        nv_pkg::cnt_t cnt;
        logic done;
    } timer_state_t;

    timer_state_t st_r;
    timer_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (tmr.start) begin
            st_nxt.run = 1'b1;
            st_nxt.cnt = tmr.load;
        end else if (st_r.run) begin
            if (st_r.cnt <= nv_pkg::CNT_ONE) begin
                st_nxt.run = 1'b0;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt - nv_pkg::CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tmr.done = st_r.done;
endmodule
`default_nettype wire

// >>> hw/nv_access_ctrl.sv
/*
 * Register front end and sequencer of the nonvolatile byte array:
 * address pair, data byte, unlock port, access control and done flag.
 * Assumes a core that issues one register access per cycle on sfr_*.
 */
// What this block does
// - Byte read and write through data register
// - Array reached only through special registers
// - Each byte write erases before programming
// - Write duration set by internal self-timer
// - Address high keeps only two low bits
// - Ten-bit address covers whole array
// - Program-space select steers away from array
// - Config-space select reaches configuration space
// - Write needs permit bit, clear after power-up
// - Error flag set by permit, cleared on completion
// - Write start set-only, hardware clears it
// - Completion sets sticky done flag bit four
// - Read start launches read, self-clearing
// - Read start refused while program space selected
// - Unlock port stores nothing, reads zero
// - Unimplemented bits read back as zero
`timescale 1ns/100ps
`default_nettype none
module nv_access_ctrl #(
    parameter int ERASE_WAIT = nv_pkg::ERASE_CYCLES,
    parameter int PROGRAM_WAIT = nv_pkg::PROGRAM_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sys_reset_req,
    input wire logic [2:0] sfr_sel,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic nv_busy,
    output logic nv_done_flag,
    output logic alt_space_write,
    output logic alt_space_cfg
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        nv_pkg::ctrl_state_t state;
        nv_pkg::lock_state_t lock;
        logic [nv_pkg::ADDR_HIGH_W-1:0] addr_high;
        logic [7:0] addr_low;
        logic [7:0] data;
        logic pgd;
        logic cfg;
        logic free;
        logic err;
        logic permit;
        logic wr;
        logic rd;
        logic done_flag;
        logic [nv_pkg::ADDR_W-1:0] wr_addr;
        logic [7:0] wr_data;
        logic [7:0] rdata;
        logic busy;
        logic alt_wr;
        logic alt_cfg;
    } ctrl_regs_t;

    ctrl_regs_t r;
    ctrl_regs_t nxt;
    logic ctl_wr;
    logic wr_go;
    logic rd_go;
    logic erase_go;
    logic prog_go;

    nv_array_if arr();
    nv_timer_if tmr();

    nv_byte_array u_array (
        .clk(clk),
        .reset_n(reset_n),
        .mem(arr)
    );

    nv_write_timer u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .tmr(tmr)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Location formed from the address pair
    function automatic logic [nv_pkg::ADDR_W-1:0] nv_location(input logic [nv_pkg::ADDR_HIGH_W-1:0] high,
            input logic [7:0] low);
        return {high, low};
    endfunction

    // True when a control byte selects neither program nor configuration space
    function automatic logic targets_array(input logic [7:0] ctl);
        return !ctl[nv_pkg::CTL_PGD] && !ctl[nv_pkg::CTL_CFG];
    endfunction

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    assign ctl_wr = sfr_wr && (sfr_sel == nv_pkg::SEL_CONTROL);
    // Write start needs permit, a fresh unlock and an idle sequencer
    assign wr_go = ctl_wr && sfr_wdata[nv_pkg::CTL_WR] && r.permit && !sys_reset_req
        && (r.lock == nv_pkg::LK_ARMED) && (r.state == nv_pkg::ST_IDLE) && !r.rd;
    assign erase_go = wr_go && targets_array(sfr_wdata);
    // Read start is refused while program or configuration space is selected
    assign rd_go = ctl_wr && sfr_wdata[nv_pkg::CTL_RD] && targets_array(sfr_wdata)
        && (r.state == nv_pkg::ST_IDLE) && !r.wr && !sys_reset_req;
    assign prog_go = (r.state == nv_pkg::ST_ERASE) && tmr.done && !sys_reset_req;

    // ------------------------------------------------------------
    // Array and timer drive
    // ------------------------------------------------------------
    assign arr.rd_en = (r.state == nv_pkg::ST_RD_ISSUE);
    assign arr.wr_en = erase_go || prog_go;
    assign arr.wdata = erase_go ? nv_pkg::ERASED_BYTE : r.wr_data;
    assign arr.addr = (r.state == nv_pkg::ST_ERASE) ? r.wr_addr : nv_location(r.addr_high, r.addr_low);
    assign tmr.start = erase_go || prog_go;
    assign tmr.load = erase_go ? nv_pkg::cnt_t'(ERASE_WAIT) : nv_pkg::cnt_t'(PROGRAM_WAIT);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt = r;
        nxt.alt_wr = 1'b0;
        // Any register write other than to the unlock port breaks the key
        if (sfr_wr && (sfr_sel != nv_pkg::SEL_UNLOCK)) begin
            nxt.lock = nv_pkg::LK_NONE;
        end
        if (sfr_wr) begin
            case (sfr_sel)
                nv_pkg::SEL_ADDR_HIGH: begin
                    nxt.addr_high = sfr_wdata[nv_pkg::ADDR_HIGH_W-1:0];
                end
                nv_pkg::SEL_ADDR_LOW: begin
                    nxt.addr_low = sfr_wdata;
                end
                nv_pkg::SEL_DATA: begin
                    nxt.data = sfr_wdata;
                end
                nv_pkg::SEL_UNLOCK: begin
                    if (sfr_wdata == nv_pkg::UNLOCK_KEY_FIRST) begin
                        nxt.lock = nv_pkg::LK_FIRST;
                    end else if ((r.lock == nv_pkg::LK_FIRST) && (sfr_wdata == nv_pkg::UNLOCK_KEY_SECOND)) begin
                        nxt.lock = nv_pkg::LK_ARMED;
                    end else begin
                        nxt.lock = nv_pkg::LK_NONE;
                    end
                end
                nv_pkg::SEL_CONTROL: begin
                    nxt.pgd = sfr_wdata[nv_pkg::CTL_PGD];
                    nxt.cfg = sfr_wdata[nv_pkg::CTL_CFG];
                    nxt.free = sfr_wdata[nv_pkg::CTL_FREE];
                    nxt.err = sfr_wdata[nv_pkg::CTL_ERR];
                    nxt.permit = sfr_wdata[nv_pkg::CTL_PERMIT];
                    // Setting permit marks a write as not yet completed
                    if (sfr_wdata[nv_pkg::CTL_PERMIT] && !r.permit) begin
                        nxt.err = 1'b1;
                    end
                end
                nv_pkg::SEL_PFLAG6: begin
                    nxt.done_flag = sfr_wdata[nv_pkg::DONE_BIT];
                end
                default: begin
                    nxt.lock = nv_pkg::LK_NONE;
                end
            endcase
        end
        if (wr_go) begin
            nxt.lock = nv_pkg::LK_NONE;
        end
        // Writes aimed at program or configuration space leave the array alone
        if (wr_go && !erase_go) begin
            nxt.alt_wr = 1'b1;
            nxt.alt_cfg = sfr_wdata[nv_pkg::CTL_CFG];
        end
        case (r.state)
            nv_pkg::ST_IDLE: begin
                if (rd_go) begin
                    nxt.rd = 1'b1;
                    nxt.state = nv_pkg::ST_RD_ISSUE;
                end else if (erase_go) begin
                    nxt.wr = 1'b1;
                    nxt.wr_addr = nv_location(r.addr_high, r.addr_low);
                    nxt.wr_data = r.data;
                    nxt.state = nv_pkg::ST_ERASE;
                end
            end
            nv_pkg::ST_RD_ISSUE: begin
                nxt.state = nv_pkg::ST_RD_LOAD;
            end
            nv_pkg::ST_RD_LOAD: begin
                nxt.data = arr.rdata;
                nxt.rd = 1'b0;
                nxt.state = nv_pkg::ST_IDLE;
            end
            nv_pkg::ST_ERASE: begin
                if (tmr.done) begin
                    nxt.state = nv_pkg::ST_PROGRAM;
                end
            end
            nv_pkg::ST_PROGRAM: begin
                if (tmr.done) begin
                    nxt.wr = 1'b0;
                    nxt.err = 1'b0;
                    nxt.done_flag = 1'b1;
                    nxt.state = nv_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt.state = nv_pkg::ST_IDLE;
            end
        endcase
        // A core reset aborts any operation but keeps the error flag
        if (sys_reset_req) begin
            nxt.state = nv_pkg::ST_IDLE;
            nxt.lock = nv_pkg::LK_NONE;
            nxt.wr = 1'b0;
            nxt.rd = 1'b0;
            nxt.permit = 1'b0;
            nxt.alt_wr = 1'b0;
        end
        nxt.busy = (nxt.state != nv_pkg::ST_IDLE);
        // Read answer, unimplemented bits as zero
        nxt.rdata = nv_pkg::ZERO_BYTE;
        if (sfr_rd) begin
            case (sfr_sel)
                nv_pkg::SEL_ADDR_HIGH: begin
                    nxt.rdata = {6'h00, r.addr_high};
                end
                nv_pkg::SEL_ADDR_LOW: begin
                    nxt.rdata = r.addr_low;
                end
                nv_pkg::SEL_DATA: begin
                    nxt.rdata = r.data;
                end
                nv_pkg::SEL_CONTROL: begin
                    nxt.rdata = {r.pgd, r.cfg, 1'b0, r.free, r.err, r.permit, r.wr, r.rd};
                end
                nv_pkg::SEL_PFLAG6: begin
                    nxt.rdata = {3'h0, r.done_flag, 4'h0};
                end
                default: begin
                    nxt.rdata = nv_pkg::ZERO_BYTE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign sfr_rdata = r.rdata;
    assign nv_busy = r.busy;
    assign nv_done_flag = r.done_flag;
    assign alt_space_write = r.alt_wr;
    assign alt_space_cfg = r.alt_cfg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n || sys_reset_req);

    sequence s_read_steps;
        (r.state == nv_pkg::ST_RD_ISSUE) ##1 (r.state == nv_pkg::ST_RD_LOAD)
            ##1 (r.state == nv_pkg::ST_IDLE && !r.rd);
    endsequence

    sequence s_erase_phase;
        (r.state == nv_pkg::ST_ERASE) && r.wr;
    endsequence

    sequence s_program_phase;
        (r.state == nv_pkg::ST_PROGRAM) && r.wr;
    endsequence

    sequence s_program_strobe;
        arr.wr_en && (arr.addr == r.wr_addr) && (arr.wdata == r.wr_data);
    endsequence

    a_read_steps: assert property ($rose(r.rd) |-> s_read_steps)
        else $error("read start did not complete in two cycles");
    a_read_data: assert property ((r.state == nv_pkg::ST_RD_LOAD) |=> (r.data == $past(arr.rdata)))
        else $error("read byte not loaded into data register");
    a_read_refused: assert property ((ctl_wr && sfr_wdata[nv_pkg::CTL_PGD]) |=> !$rose(r.rd))
        else $error("read started with program space selected");
    a_write_permit: assert property ($rose(r.wr) |-> ($past(r.permit) && $past(r.lock) == nv_pkg::LK_ARMED))
        else $error("write started without permit or unlock");
    a_erase_first: assert property ($rose(r.wr) |-> s_erase_phase ##0
        ($past(arr.wr_en) && $past(arr.wdata) == nv_pkg::ERASED_BYTE))
        else $error("write did not begin by erasing the byte");
    a_phase_order: assert property ((s_erase_phase ##0 tmr.done) |=> s_program_phase)
        else $error("erase phase not followed by program phase");
    a_write_held: assert property ((r.wr && !sys_reset_req
        && !(r.state == nv_pkg::ST_PROGRAM && tmr.done)) |=> r.wr)
        else $error("write start cleared before completion");
    a_write_done: assert property ((s_program_phase ##0 tmr.done)
        |=> (r.done_flag && !r.wr && !r.err && !r.busy))
        else $error("completion did not set done flag and clear status");
    a_error_set: assert property ((ctl_wr && sfr_wdata[nv_pkg::CTL_PERMIT] && !r.permit) |=> r.err)
        else $error("setting permit did not raise the error flag");
    a_unlock_zero: assert property ((sfr_rd && sfr_sel == nv_pkg::SEL_UNLOCK)
        |=> (sfr_rdata == nv_pkg::ZERO_BYTE))
        else $error("unlock port read back nonzero");
    a_high_zero: assert property ((sfr_rd && sfr_sel == nv_pkg::SEL_ADDR_HIGH)
        |=> (sfr_rdata == {6'h00, $past(r.addr_high)}))
        else $error("address high upper bits not zero");
    a_addr_pair: assert property (arr.rd_en |-> (arr.addr == {r.addr_high, r.addr_low}))
        else $error("array address not formed from the register pair");
    a_program_byte: assert property ((s_erase_phase ##0 tmr.done) |-> s_program_strobe)
        else $error("program strobe missing or wrong byte after erase");
    a_timer_start: assert property ($rose(r.wr) |-> ($past(tmr.start) && $past(tmr.load) == ERASE_WAIT))
        else $error("self-timer not started for the erase phase");
    a_done_sticky: assert property ((r.done_flag && !(sfr_wr && sfr_sel == nv_pkg::SEL_PFLAG6)) |=> r.done_flag)
        else $error("done flag cleared without a software write");
    a_write_refused: assert property ((ctl_wr && sfr_wdata[nv_pkg::CTL_WR] && !r.permit) |=> !$rose(r.wr))
        else $error("write started without permit");
    a_unlock_needed: assert property ((ctl_wr && sfr_wdata[nv_pkg::CTL_WR]
        && r.lock != nv_pkg::LK_ARMED) |=> !$rose(r.wr))
        else $error("write started without unlock");
    a_lock_cleared: assert property (wr_go |=> (r.lock == nv_pkg::LK_NONE))
        else $error("unlock not consumed by write start");
    a_alt_untouched: assert property ((wr_go && !erase_go) |=> (r.alt_wr && !r.wr))
        else $error("program space write touched the array");
    a_read_launch: assert property (rd_go |=> (r.rd && r.busy))
        else $error("read start did not launch a read");
endmodule
`default_nettype wire

// >>> verif/testbench.sv
/*
 * Self-checking bench for the nonvolatile byte array controller top.
 * Assumes hw/ package, carriers and design modules are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int ERASE_W = 8;
    localparam int PROG_W = 8;
    logic clk;
    logic reset_n;
    logic sys_reset_req;
    logic [2:0] sfr_sel;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic nv_busy;
    logic nv_done_flag;
    logic alt_space_write;
    logic alt_space_cfg;
    logic alt_seen;
    int n_mismatch;
    int num_checks;

    nv_access_ctrl #(.ERASE_WAIT(ERASE_W), .PROGRAM_WAIT(PROG_W)) dut_u (
        .clk(clk),
        .reset_n(reset_n),
        .sys_reset_req(sys_reset_req),
        .sfr_sel(sfr_sel),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .nv_busy(nv_busy),
        .nv_done_flag(nv_done_flag),
        .alt_space_write(alt_space_write),
        .alt_space_cfg(alt_space_cfg)
    );

    // ------------------------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic reg_write(input logic [2:0] sel, input logic [7:0] data);
        @(posedge clk);
        sfr_sel <= sel;
        sfr_wdata <= data;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        #1;
        alt_seen = alt_space_write;
    endtask

    task automatic reg_read(input logic [2:0] sel, output logic [7:0] data);
        @(posedge clk);
        sfr_sel <= sel;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        data = sfr_rdata;
    endtask

    task automatic wait_busy(input logic level, input int limit);
        for (int i = 0; i < limit && nv_busy !== level; i++) begin
            @(posedge clk);
            #1;
        end
        check1(nv_busy, level, "busy wait");
    endtask

    task automatic unlock();
        reg_write(nv_pkg::SEL_UNLOCK, nv_pkg::UNLOCK_KEY_FIRST);
        reg_write(nv_pkg::SEL_UNLOCK, nv_pkg::UNLOCK_KEY_SECOND);
    endtask

    task automatic start_write(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] data);
        logic [7:0] d;
        reg_write(nv_pkg::SEL_ADDR_HIGH, hi);
        reg_write(nv_pkg::SEL_ADDR_LOW, lo);
        reg_write(nv_pkg::SEL_DATA, data);
        reg_write(nv_pkg::SEL_CONTROL, 8'h00);
        reg_write(nv_pkg::SEL_CONTROL, 8'h04);
        reg_read(nv_pkg::SEL_CONTROL, d);
        check8(d, 8'h0C, "permit sets error flag");
        unlock();
        reg_write(nv_pkg::SEL_CONTROL, 8'h0E);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        logic [7:0] d;
        for (int s = 0; s < 8; s++) begin
            reg_read(s[2:0], d);
            check8(d, 8'h00, "value after power-up");
        end
    endtask

    task automatic t_address_high();
        logic [7:0] d;
        reg_write(nv_pkg::SEL_ADDR_HIGH, 8'hFF);
        reg_read(nv_pkg::SEL_ADDR_HIGH, d);
        check8(d, 8'h03, "address high upper bits");
        reg_write(nv_pkg::SEL_UNLOCK, 8'h5A);
        reg_read(nv_pkg::SEL_UNLOCK, d);
        check8(d, 8'h00, "unlock port readback");
    endtask

    task automatic t_write(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] data);
        logic [7:0] d;
        start_write(hi, lo, data);
        reg_read(nv_pkg::SEL_CONTROL, d);
        check8(d, 8'h0E, "write running");
        reg_write(nv_pkg::SEL_CONTROL, 8'h0C);
        reg_read(nv_pkg::SEL_CONTROL, d);
        check8(d, 8'h0E, "write start not clearable");
        wait_busy(1'b0, 60);
        check1(nv_done_flag, 1'b1, "done flag set");
        reg_read(nv_pkg::SEL_CONTROL, d);
        check8(d, 8'h04, "control after write");
        reg_read(nv_pkg::SEL_PFLAG6, d);
        check8(d, 8'h10, "flag register bit four");
    endtask

    task automatic t_read(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] exp);
        logic [7:0] d;
        reg_write(nv_pkg::SEL_ADDR_HIGH, hi);
        reg_write(nv_pkg::SEL_ADDR_LOW, lo);
        reg_write(nv_pkg::SEL_DATA, 8'h00);
        reg_write(nv_pkg::SEL_CONTROL, 8'h01);
        wait_busy(1'b0, 10);
        reg_read(nv_pkg::SEL_CONTROL, d);
        check8(d, 8'h00, "read start self-clears");
        reg_read(nv_pkg::SEL_DATA, d);
        check8(d, exp, "byte read back");
    endtask

    task automatic t_done_clear();
        logic [7:0] d;
        reg_write(nv_pkg::SEL_PFLAG6, 8'h00);
        check1(nv_done_flag, 1'b0, "done flag cleared");
        reg_read(nv_pkg::SEL_PFLAG6, d);
        check8(d, 8'h00, "flag register cleared");
    endtask

    task automatic t_refused();
        reg_write(nv_pkg::SEL_CONTROL, 8'h04);
        reg_write(nv_pkg::SEL_CONTROL, 8'h06);
        repeat (3) @(posedge clk);
        #1;
        check1(nv_busy, 1'b0, "write without unlock");
        reg_write(nv_pkg::SEL_CONTROL, 8'h00);
        unlock();
        reg_write(nv_pkg::SEL_CONTROL, 8'h02);
        repeat (3) @(posedge clk);
        #1;
        check1(nv_busy, 1'b0, "write without permit");
        reg_write(nv_pkg::SEL_CONTROL, 8'h04);
        unlock();
        reg_write(3'h6, 8'h00);
        reg_write(nv_pkg::SEL_CONTROL, 8'h06);
        repeat (3) @(posedge clk);
        #1;
        check1(nv_busy, 1'b0, "unlock broken by unmapped write");
        check1(nv_done_flag, 1'b0, "no completion");
    endtask

    task automatic t_alt_space();
        logic [7:0] d;
        reg_write(nv_pkg::SEL_CONTROL, 8'h84);
        unlock();
        reg_write(nv_pkg::SEL_CONTROL, 8'h86);
        check1(alt_seen, 1'b1, "program space write");
        check1(alt_space_cfg, 1'b0, "program space target");
        unlock();
        reg_write(nv_pkg::SEL_CONTROL, 8'hC6);
        check1(alt_seen, 1'b1, "config space write");
        check1(alt_space_cfg, 1'b1, "config space target");
        reg_write(nv_pkg::SEL_CONTROL, 8'h81);
        check1(nv_busy, 1'b0, "read refused in program space");
        reg_read(nv_pkg::SEL_CONTROL, d);
        check8(d, 8'h80, "read start stays clear");
    endtask

    task automatic t_abort();
        logic [7:0] d;
        start_write(8'h01, 8'h23, 8'h77);
        wait_busy(1'b1, 5);
        @(posedge clk);
        sys_reset_req <= 1'b1;
        @(posedge clk);
        sys_reset_req <= 1'b0;
        @(posedge clk);
        #1;
        check1(nv_busy, 1'b0, "core reset aborts write");
        reg_read(nv_pkg::SEL_CONTROL, d);
        check8(d, 8'h08, "error flag kept after abort");
    endtask

    // ------------------------------------------------------------
    // Clock, reset, sequence and verdict
    // ------------------------------------------------------------
    task results();
        $display("Checks: %0d, mismatches: %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #(5 * 8000);
        n_mismatch++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        results();
    end

    initial begin
        n_mismatch = 0;
        num_checks = 0;
        alt_seen = 1'b0;
        reset_n = 1'b0;
        sys_reset_req = 1'b0;
        sfr_sel = 3'h0;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        t_reset_values();
        t_address_high();
        t_write(8'hFF, 8'hFF, 8'hA5);
        t_write(8'hFC, 8'h00, 8'h3C);
        t_done_clear();
        t_write(8'hFF, 8'hFF, 8'h5A);
        t_read(8'h00, 8'h00, 8'h3C);
        t_read(8'h03, 8'hFF, 8'h5A);
        t_done_clear();
        t_refused();
        t_alt_space();
        t_read(8'h03, 8'hFF, 8'h5A);
        t_abort();
        results();
    end
endmodule
`default_nettype wire
